// ==== qpt_pkg.sv ====
// Constants and carrier types of the panel timing host controller.
package qpt_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [2:0] DOT_LAST = 3'h7;
	localparam logic [2:0] DOT_HALF = 3'h4;
	localparam logic [2:0] DOT_TICK = 3'h3;
	localparam logic [7:0] H_ACT = 8'hF0;
	localparam logic [7:0] H_SYNC_S = 8'hF4;
	localparam logic [7:0] H_SYNC_E = 8'hFC;
	localparam logic [7:0] H_LAST = 8'hFF;
	localparam logic [8:0] V_ACT = 9'h140;
	localparam logic [8:0] V_SYNC_S = 9'h141;
	localparam logic [8:0] V_SYNC_E = 9'h143;
	localparam logic [8:0] V_LAST = 9'h143;
	localparam int RST_LOW_NS = 2000;
	localparam int RST_LOW_CYC =
		(RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_WAIT_MS = 1;
	localparam int RST_WAIT_CYC =
		(RST_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_RD_NS = 450;
	localparam int SCL_WR_NS = 100;
	localparam int SCL_RD_HALF = 10;
	localparam int SCL_WR_HALF =
		(SCL_WR_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] HALF_RD = 4'(SCL_RD_HALF - 1);
	localparam logic [3:0] HALF_WR = 4'(SCL_WR_HALF - 1);
	localparam logic [4:0] SER_LAST_BIT = 5'h0F;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;
	typedef struct packed {
		logic [5:0] red_field;
		logic [5:0] green_field;
		logic [5:0] blue_field;
	} qpt_pix_t;
	typedef struct packed {
		logic     dot_clk;
		logic     hsync_n;
		logic     vsync_n;
		logic     de;
		qpt_pix_t pix;
	} qpt_video_t;
	typedef struct packed {
		logic        rd;
		logic [15:0] wdata;
	} qpt_ser_req_t;
	typedef enum logic [1:0] {I_RST, I_WAIT, I_RUN} qpt_init_t;
	typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_HOLD} qpt_ser_t;
endpackage : qpt_pkg

// ==== qpt_host.sv ====
// Host controller driving the panel video bus, reset and serial port.
`timescale 1ns/100ps
// Functional notes
// - Dot clock is ref_clk divided by eight, 5.0 MHz, one pixel each.
// - Every line lasts 256 dot clocks.
// - Each active line carries 240 consecutive valid pixels.
// - Four dot clock front porch precedes the line sync.
// - Line sync pulse is held for eight dot clocks.
// - Four dot clock back porch follows the line sync.
// - Every frame spans 324 line periods.
// - 320 lines per frame carry pixels, the rest carry none.
// - One line front porch precedes the frame sync.
// - Frame sync pulse is held for two line periods.
// - One line back porch follows the frame sync.
// - Panel reset is driven low at least 2 microseconds.
// - Chip select waits at least 1 ms after panel reset release.
// - Serial clock period is 500 ns on reads, 100 ns on writes.
// - Pixel is three 6-bit fields red, green, blue, MSB first.
module qpt_host #(
	parameter int WAIT_CYC = qpt_pkg::RST_WAIT_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire qpt_pkg::qpt_pix_t     pix_in,
	input  wire logic                  pix_valid,
	output logic                       pix_ready,
	output qpt_pkg::qpt_video_t        video,
	output logic                       frame_start,
	output logic                       underrun,
	output logic                       panel_rst_n,
	output logic                       init_done,
	input  wire qpt_pkg::qpt_ser_req_t ser_req,
	input  wire logic                  ser_valid,
	output logic                       ser_ready,
	output logic                       ser_done,
	output logic [15:0]                ser_rdata,
	output logic                       ser_cs_n,
	output logic                       ser_scl,
	output logic                       ser_si,
	input  wire logic                  ser_so
);
	import qpt_pkg::*;

	typedef struct packed {
		logic [2:0]                  phase;
		logic                        dot_clk;
		logic [7:0]                  hcnt;
		logic [8:0]                  vcnt;
		logic                        hsync_n;
		logic                        vsync_n;
		logic                        de;
		qpt_pix_t                    pix;
		logic                        sof;
		logic                        urun;
		qpt_pix_t [BUF_DEPTH-1:0]    mem;
		logic                        wptr;
		logic                        rptr;
		logic [1:0]                  count;
		qpt_init_t                   init;
		logic [15:0]                 icnt;
		logic                        prst_n;
		qpt_ser_t                    ser;
		logic [3:0]                  scnt;
		logic [4:0]                  bitn;
		logic [15:0]                 shreg;
		logic                        rdsel;
		logic                        cs_n;
		logic                        scl;
		logic                        si;
		logic [15:0]                 rdata;
		logic                        done;
		logic                        so_m;
		logic                        so_s;
	} qpt_state_t;

	qpt_state_t s;
	qpt_state_t next_s;

	logic tick;
	logic act;
	logic push;
	logic pop;
	logic [3:0] half;

	assign pix_ready = (s.count != BUF_FULL);
	assign ser_ready = (s.init == I_RUN) && (s.ser == S_IDLE);
	assign push = pix_valid && pix_ready;
	assign tick = (s.phase == DOT_TICK) && (s.init == I_RUN);
	assign act = (s.hcnt < H_ACT) && (s.vcnt < V_ACT);
	assign pop = tick && act && (s.count != 2'h0);
	assign half = s.rdsel ? HALF_RD : HALF_WR;

	always_comb begin
		next_s = s;
		next_s.sof = 1'b0;
		next_s.urun = 1'b0;
		next_s.done = 1'b0;

		// Dot clock divider, rising at phase 0, falling at phase 4.
		if (s.phase == DOT_LAST) begin
			next_s.phase = 3'h0;
		end else begin
			next_s.phase = s.phase + 3'h1;
		end
		next_s.dot_clk = (next_s.phase < DOT_HALF);

		// Two-entry pixel buffer between the source and the bus.
		if (push) begin
			next_s.mem[s.wptr] = pix_in;
			next_s.wptr = ~s.wptr;
		end
		if (pop) begin
			next_s.rptr = ~s.rptr;
		end
		if (push && !pop) begin
			next_s.count = s.count + 2'h1;
		end else if (pop && !push) begin
			next_s.count = s.count - 2'h1;
		end

		// Bus outputs change on the falling dot clock edge.
		if (tick) begin
			next_s.de = act;
			next_s.hsync_n = !((s.hcnt >= H_SYNC_S) &&
				(s.hcnt < H_SYNC_E));
			next_s.vsync_n = !((s.vcnt >= V_SYNC_S) &&
				(s.vcnt < V_SYNC_E));
			next_s.sof = (s.hcnt == 8'h00) && (s.vcnt == 9'h000);
			if (act) begin
				if (s.count != 2'h0) begin
					next_s.pix = s.mem[s.rptr];
				end else begin
					next_s.pix = '0;
					next_s.urun = 1'b1;
				end
			end else begin
				next_s.pix = '0;
			end
			if (s.hcnt == H_LAST) begin
				next_s.hcnt = 8'h00;
				if (s.vcnt == V_LAST) begin
					next_s.vcnt = 9'h000;
				end else begin
					next_s.vcnt = s.vcnt + 9'h001;
				end
			end else begin
				next_s.hcnt = s.hcnt + 8'h01;
			end
		end

		// Panel reset and power-up wait.
		case (s.init)
			I_RST: begin
				next_s.prst_n = 1'b0;
				if (s.icnt == 16'(RST_LOW_CYC - 1)) begin
					next_s.icnt = 16'h0000;
					next_s.prst_n = 1'b1;
					next_s.init = I_WAIT;
				end else begin
					next_s.icnt = s.icnt + 16'h0001;
				end
			end
			I_WAIT: begin
				if (s.icnt == 16'(WAIT_CYC - 1)) begin
					next_s.icnt = 16'h0000;
					next_s.init = I_RUN;
				end else begin
					next_s.icnt = s.icnt + 16'h0001;
				end
			end
			I_RUN: begin
				next_s.init = I_RUN;
			end
			default: begin
				next_s.init = I_RST;
			end
		endcase

		// Serial port, MSB first: SO seen at the rise is shifted in at the fall.
		// The two sync flops lag two cycles, so the fall still holds that value.
		next_s.so_m = ser_so;
		next_s.so_s = s.so_m;
		case (s.ser)
			S_IDLE: begin
				if (ser_valid && ser_ready) begin
					next_s.cs_n = 1'b0;
					next_s.rdsel = ser_req.rd;
					next_s.shreg = ser_req.wdata;
					next_s.si = ser_req.wdata[15];
					next_s.bitn = SER_LAST_BIT;
					next_s.scnt = ser_req.rd ? HALF_RD : HALF_WR;
					next_s.ser = S_LOW;
				end
			end
			S_LOW: begin
				if (s.scnt == 4'h0) begin
					next_s.scl = 1'b1;
					next_s.scnt = half;
					next_s.ser = S_HIGH;
				end else begin
					next_s.scnt = s.scnt - 4'h1;
				end
			end
			S_HIGH: begin
				if (s.scnt == 4'h0) begin
					next_s.scl = 1'b0;
					next_s.shreg = {s.shreg[14:0], s.so_s};
					next_s.scnt = half;
					if (s.bitn == 5'h00) begin
						next_s.ser = S_HOLD;
					end else begin
						next_s.bitn = s.bitn - 5'h01;
						next_s.si = s.shreg[14];
						next_s.ser = S_LOW;
					end
				end else begin
					next_s.scnt = s.scnt - 4'h1;
				end
			end
			S_HOLD: begin
				if (s.scnt == 4'h0) begin
					next_s.cs_n = 1'b1;
					next_s.si = 1'b0;
					next_s.rdata = s.shreg;
					next_s.done = 1'b1;
					next_s.ser = S_IDLE;
				end else begin
					next_s.scnt = s.scnt - 4'h1;
				end
			end
			default: begin
				next_s.ser = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.hsync_n <= 1'b1;
			s.vsync_n <= 1'b1;
			// Start at the first frame sync line so the first frame gets the full sync pulse and back porch.
			s.vcnt <= V_SYNC_S;
			s.init <= I_RST;
			s.ser <= S_IDLE;
			s.cs_n <= 1'b1;
			s.dot_clk <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign video = '{
		dot_clk: s.dot_clk,
		hsync_n: s.hsync_n,
		vsync_n: s.vsync_n,
		de:      s.de,
		pix:     s.pix
	};
	assign frame_start = s.sof;
	assign underrun = s.urun;
	assign panel_rst_n = s.prst_n;
	assign init_done = (s.init == I_RUN);
	assign ser_done = s.done;
	assign ser_rdata = s.rdata;
	assign ser_cs_n = s.cs_n;
	assign ser_scl = s.scl;
	assign ser_si = s.si;
endmodule : qpt_host

// ==== qpt_props.sv ====
// Port checker of the panel timing host controller.
`timescale 1ns/100ps
module qpt_props (
	input wire logic                ref_clk,
	input wire logic                rst_n,
	input wire qpt_pkg::qpt_video_t video,
	input wire logic                panel_rst_n,
	input wire logic                init_done,
	input wire logic                ser_cs_n,
	input wire logic                ser_scl,
	input wire logic                frame_start
);
	import qpt_pkg::*;
	int act;
	int per;
	int vlow;
	int vgap;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence hs_end;
		##63 !video.hsync_n ##1 video.hsync_n;
	endsequence
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) begin
			act <= 0;
			per <= 0;
			vlow <= 0;
			vgap <= 0;
		end else begin
			act <= video.de ? act + 1 : 0;
			per <= $fell(video.hsync_n) ? 1 : (per != 0 ? per + 1 : 0);
			vlow <= !video.vsync_n ? vlow + 1 : 0;
			if ($rose(video.vsync_n)) begin
				vgap <= 1;
			end else if ($rose(video.de)) begin
				vgap <= 0;
			end else if (vgap != 0) begin
				vgap <= vgap + 1;
			end
		end
	a_dot_rate: assert property ($rose(video.dot_clk) |->
		video.dot_clk [*4] ##1 !video.dot_clk [*4]) else $error("dot clock");
	a_line_len: assert property ($fell(video.hsync_n) && per != 0 |->
		per == 2048) else $error("line length");
	a_act_len: assert property ($fell(video.de) |->
		act == 1920) else $error("active length");
	a_front_porch: assert property ($fell(video.de) |->
		##31 video.hsync_n ##1 !video.hsync_n) else $error("front porch");
	a_sync_width: assert property ($fell(video.hsync_n) |->
		hs_end) else $error("line sync width");
	a_back_porch: assert property ($rose(video.de) |->
		$past(video.hsync_n, 32) && !$past(video.hsync_n, 33))
		else $error("back porch");
	a_blank_black: assert property (!video.de |->
		video.pix == '0) else $error("blank pixel");
	a_prst_width: assert property ($rose(panel_rst_n) |->
		!$past(panel_rst_n, 80)) else $error("panel reset width");
	a_cs_wait: assert property ($fell(ser_cs_n) |->
		init_done && panel_rst_n) else $error("chip select early");
	a_scl_high: assert property ($rose(ser_scl) |->
		##1 ser_scl) else $error("serial clock high");
	a_vsync_width: assert property ($rose(video.vsync_n) |->
		vlow == 4096) else $error("frame sync width");
	a_vback_porch: assert property ($rose(video.de) && vgap != 0
		|-> vgap == 2048) else $error("vertical back porch");
	a_frame_first: assert property (frame_start |->
		$rose(video.de) && video.vsync_n) else $error("frame start");
endmodule : qpt_props
bind qpt_host qpt_props chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.video(video), .panel_rst_n(panel_rst_n), .init_done(init_done),
	.ser_cs_n(ser_cs_n), .ser_scl(ser_scl), .frame_start(frame_start));

// ==== qpt_panel_model.sv ====
// Behavioural panel: pixel capture and serial port slave.
`timescale 1ns/100ps
module qpt_panel_model #(
	parameter logic [15:0] RD_WORD = 16'h5A3C
) (
	input  wire qpt_pkg::qpt_video_t video,
	input  wire logic                ser_cs_n,
	input  wire logic                ser_scl,
	input  wire logic                ser_si,
	output logic                     ser_so,
	output qpt_pkg::qpt_pix_t        px,
	output logic                     px_new,
	output logic [15:0]              rx
);
	import qpt_pkg::*;
	logic [3:0] bi = 4'hF;
	logic       q  = 1'b0;
	logic       tog = 1'b0;
	assign px_new = tog;
	always @(posedge video.dot_clk)
		if (video.de) begin
			px <= video.pix;
			tog <= !tog;
		end
	always @(negedge ser_scl or posedge ser_cs_n)
		if (ser_cs_n) begin
			q <= !RD_WORD[bi];
			bi <= 4'hF;
		end else begin
			bi <= bi - 4'h1;
		end
	always @(posedge ser_scl)
		if (!ser_cs_n) rx <= {rx[14:0], ser_si};
	assign ser_so = ser_cs_n ? q : RD_WORD[bi];
endmodule : qpt_panel_model

// ==== qpt_panel_rgb_timing_tb_top.sv ====
// Self-checking bench of the panel timing host controller.
`timescale 1ns/100ps
module qpt_panel_rgb_timing_tb_top;
	import qpt_pkg::*;
	localparam logic [15:0] RDW = 16'h5A3C;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	qpt_pix_t     pix_in = '0;
	logic         pix_valid = 1'b0;
	logic         feed = 1'b1;
	logic         take = 1'b0;
	qpt_ser_req_t ser_req = '0;
	logic         ser_valid = 1'b0;
	logic         pix_ready, frame_start, underrun, panel_rst_n, init_done;
	logic         ser_ready, ser_done, ser_cs_n, ser_scl, ser_si, ser_so;
	logic [15:0]  ser_rdata, rx;
	qpt_video_t   video;
	qpt_pix_t     px;
	logic         px_new;
	logic [15:0]  lf = 16'hC25C;
	int           failures = 0;
	int           n_compared = 0;
	int           n_under = 0;
	int           n_frame = 0;
	qpt_pix_t     exp_px;
	qpt_pix_t     sent[$];
	qpt_host #(.WAIT_CYC(20)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.video(video), .frame_start(frame_start), .underrun(underrun),
		.panel_rst_n(panel_rst_n), .init_done(init_done),
		.ser_req(ser_req), .ser_valid(ser_valid), .ser_ready(ser_ready),
		.ser_done(ser_done), .ser_rdata(ser_rdata), .ser_cs_n(ser_cs_n),
		.ser_scl(ser_scl), .ser_si(ser_si), .ser_so(ser_so));
	qpt_panel_model #(.RD_WORD(RDW)) panel_u (.video(video),
		.ser_cs_n(ser_cs_n), .ser_scl(ser_scl), .ser_si(ser_si),
		.ser_so(ser_so), .px(px), .px_new(px_new), .rx(rx));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic ser(input logic rd, input logic [15:0] d);
		int n;
		int h;
		@(posedge ref_clk);
		ser_req <= '{rd, d};
		ser_valid <= 1'b1;
		do @(negedge ref_clk); while (ser_ready !== 1'b1);
		@(posedge ref_clk);
		ser_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			@(negedge ref_clk);
		end while (ser_done !== 1'b1 && n < 400);
		h = rd ? SCL_RD_HALF : SCL_WR_HALF;
		chk("ser_cycles", n, (2 * 16 + 1) * h);
		chk("ser_out", rx, d);
		chk("ser_rdata", ser_rdata, RDW);
	endtask : ser
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) take = pix_valid && pix_ready;
	always @(posedge ref_clk) begin
		lf <= lfsr(lf);
		if (take) sent.push_back(pix_in);
		if (take || !pix_valid) begin
			pix_valid <= feed && rst_n && (lf[0] || lf[1]);
			pix_in <= qpt_pix_t'({lf[1:0], lf});
		end
		if (underrun === 1'b1) n_under++;
		if (frame_start === 1'b1) n_frame++;
	end
	always @(px_new) begin
		#1;
		exp_px = sent.size() ? sent.pop_front() : '0;
		if (rst_n) chk("pixel", px, exp_px);
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (79) @(posedge ref_clk);
		#1 chk("panel_rst_n low", panel_rst_n, 0);
		repeat (3) @(posedge ref_clk);
		#1 chk("panel_rst_n high", panel_rst_n, 1);
		ser(1'b0, 16'hC3A5);
		ser(1'b1, 16'h0FF0);
		repeat (9000) @(posedge ref_clk);
		chk("underrun", n_under, 0);
		feed <= 1'b0;
		repeat (4100) @(posedge ref_clk);
		chk("underrun_seen", n_under > 0, 1);
		chk("frame_start", n_frame, 1);
		end_sim();
	end
	// The run needs about 13600 cycles; over twice that cuts a hang short.
	initial begin
		#(25 * 30000);
		failures++;
		end_sim();
	end
endmodule : qpt_panel_rgb_timing_tb_top
